// ===== verilog/mrssd_core.sv
`timescale 1ns/1ps
module mrssd_core (
  // clock and reset
  input  wire  logic                  i_ref_clk,
  input  wire  logic                  i_resetn,
  // instruction request from fetch/decode
  input  wire  logic                  i_op_valid,
  input  wire  mrssd_pkg::mrssd_op_e  i_op,
  input  wire  logic [2:0]            i_bit_sel,
  input  wire  logic [7:0]            i_addr,
  output logic                        o_ready,
  // data memory operand and write port
  input  wire  logic [7:0]            i_mem_rdata,
  output logic                        o_mem_we,
  output logic [7:0]                  o_mem_addr,
  output logic [7:0]                  o_mem_wdata,
  // stack and program counter
  input  wire  logic [11:0]           i_stack_top,
  output logic                        o_stack_pop,
  output logic                        o_pc_load,
  output logic [11:0]                 o_pc_value,
  // fetch control
  output logic                        o_skip,
  output logic                        o_done,
  // interrupt enable
  input  wire  logic                  i_gie_clear,
  output logic                        o_global_interrupt_enable,
  // accumulator and status flags
  output logic [7:0]                  o_accumulator,
  output logic                        o_carry_flag,
  output logic                        o_zero_flag,
  output logic                        o_overflow_flag,
  output logic                        o_half_carry_flag
);
  import mrssd_pkg::*;

  // ----------------------------------------------------------------
  // sequencing state
  // ----------------------------------------------------------------
  typedef enum logic {
    st_run,
    st_dummy
  } mrssd_state_e;

  mrssd_state_e state;
  mrssd_state_e next_state;
  logic         take;

  // ----------------------------------------------------------------
  // operation unit
  // ----------------------------------------------------------------
  mrssd_alu_if alu_bus ();

  // operands: memory byte, accumulator and carry
  assign alu_bus.op      = i_op;
  assign alu_bus.bit_sel = i_bit_sel;
  assign alu_bus.mem     = i_mem_rdata;
  assign alu_bus.acc     = o_accumulator;
  assign alu_bus.carry   = o_carry_flag;

  mrssd_alu u_alu (
    .a (alu_bus.calc)
  );

  // ----------------------------------------------------------------
  // request handshake
  // ----------------------------------------------------------------
  // no request taken during the dummy cycle
  assign o_ready = (state == st_run);
  assign take    = i_op_valid && o_ready;

  // skip inserts one dummy cycle
  always_comb
  begin
    next_state = state;
    case (state)
      st_run:   next_state = (take && alu_bus.skip) ? st_dummy : st_run;
      st_dummy: next_state = st_run;
      default:  next_state = st_run;
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      state <= st_run;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // accumulator and flags
  // ----------------------------------------------------------------
  // accumulator written by the to-accumulator forms
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_accumulator <= ACC_RST;
    else if (take && alu_bus.wr_acc)
      o_accumulator <= alu_bus.result;
  end

  // carry altered only by through-carry rotates and subtracts
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_carry_flag <= FLAG_RST;
    else if (take && alu_bus.wr_carry)
      o_carry_flag <= alu_bus.carry_out;
  end

  // overflow, zero and half carry only from subtracts
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_overflow_flag   <= FLAG_RST;
      o_zero_flag       <= FLAG_RST;
      o_half_carry_flag <= FLAG_RST;
    end
    else if (take && alu_bus.wr_arith)
    begin
      o_overflow_flag   <= alu_bus.overflow;
      o_zero_flag       <= alu_bus.zero;
      o_half_carry_flag <= alu_bus.half_carry;
    end
  end

  // global enable: set by return, set wins over clear
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_global_interrupt_enable <= GIE_RST;
    else if (take && alu_bus.pc_load)
      o_global_interrupt_enable <= 1'b1;
    else if (i_gie_clear)
      o_global_interrupt_enable <= 1'b0;
  end

  // ----------------------------------------------------------------
  // memory write port
  // ----------------------------------------------------------------
  // write pulse one cycle after the request
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_mem_we <= 1'b0;
    else
      o_mem_we <= take && alu_bus.wr_mem;
  end

  // address and data held until the next request
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_mem_addr  <= BYTE_ZERO;
      o_mem_wdata <= BYTE_ZERO;
    end
    else if (take)
    begin
      o_mem_addr  <= i_addr;
      o_mem_wdata <= alu_bus.result;
    end
  end

  // ----------------------------------------------------------------
  // program counter, stack and fetch control
  // ----------------------------------------------------------------
  // pop the stack into the program counter on return
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_pc_load   <= 1'b0;
      o_stack_pop <= 1'b0;
      o_pc_value  <= 12'h000;
    end
    else
    begin
      o_pc_load   <= take && alu_bus.pc_load;
      o_stack_pop <= take && alu_bus.pc_load;
      if (take && alu_bus.pc_load)
        o_pc_value <= i_stack_top;
    end
  end

  // discard pulse and completion pulse
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_skip <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_skip <= take && alu_bus.skip;
      o_done <= take;
    end
  end

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  // operands captured at the request edge
  mrssd_op_e  chk_op;
  logic [7:0] chk_mem;
  logic [7:0] chk_acc;
  logic [2:0] chk_bit;
  logic       chk_carry;
  logic [8:0] chk_diff;

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      chk_op    <= op_none;
      chk_mem   <= BYTE_ZERO;
      chk_acc   <= BYTE_ZERO;
      chk_bit   <= 3'h0;
      chk_carry <= 1'b0;
    end
    else if (take)
    begin
      chk_op    <= i_op;
      chk_mem   <= i_mem_rdata;
      chk_acc   <= o_accumulator;
      chk_bit   <= i_bit_sel;
      chk_carry <= o_carry_flag;
    end
  end

  // reference sum of accumulator, inverted operand and carry
  assign chk_diff = {1'b0, chk_acc} + {1'b0, ~chk_mem} + {8'h00, chk_carry};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_take_skip;
    take && alu_bus.skip;
  endsequence

  sequence s_dummy_then_run;
    (o_skip && !o_ready) ##1 (o_ready && !o_skip);
  endsequence

  property p_return;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    take && (i_op == op_return_from_interrupt) |=> o_pc_load && o_stack_pop
      && o_global_interrupt_enable && (o_pc_value == $past(i_stack_top))
      && $stable(o_carry_flag) && $stable(o_zero_flag) && !o_mem_we;
  endproperty
  a_return: assert property (p_return) else $error("return did not reload pc");

  property p_rot_left;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_rotate_left_mem) |-> o_mem_we
      && (o_mem_wdata == {chk_mem[6:0], chk_mem[7]}) && $stable(o_carry_flag);
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left result wrong");

  property p_rot_left_acc;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_rotate_left_to_acc) |-> !o_mem_we
      && (o_accumulator == {chk_mem[6:0], chk_mem[7]});
  endproperty
  a_rot_left_acc: assert property (p_rot_left_acc) else $error("rotate to acc wrong");

  property p_rot_left_carry;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_rotate_left_carry_mem || chk_op == op_rotate_left_carry_to_acc)
      |-> (o_carry_flag == chk_mem[7])
      && (o_mem_wdata == {chk_mem[6:0], chk_carry})
      && (o_mem_we == (chk_op == op_rotate_left_carry_mem));
  endproperty
  a_rot_left_carry: assert property (p_rot_left_carry)
    else $error("left carry rotate wrong");

  property p_rot_left_carry_acc;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_rotate_left_carry_to_acc)
      |-> (o_accumulator == {chk_mem[6:0], chk_carry});
  endproperty
  a_rot_left_carry_acc: assert property (p_rot_left_carry_acc)
    else $error("acc carry rotate wrong");

  property p_rot_right;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_rotate_right_mem || chk_op == op_rotate_right_to_acc)
      |-> (o_mem_wdata == {chk_mem[0], chk_mem[7:1]}) && $stable(o_carry_flag)
      && (o_mem_we == (chk_op == op_rotate_right_mem));
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

  property p_rot_right_carry;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_rotate_right_carry_mem || chk_op == op_rotate_right_carry_to_acc)
      |-> (o_carry_flag == chk_mem[0]) && (o_mem_wdata == {chk_carry, chk_mem[7:1]});
  endproperty
  a_rot_right_carry: assert property (p_rot_right_carry)
    else $error("right carry rotate wrong");

  property p_subtract;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_subtract_borrow_to_acc || chk_op == op_subtract_borrow_to_mem)
      |-> (o_mem_wdata == chk_diff[7:0]) && (o_carry_flag == chk_diff[8])
      && (o_zero_flag == (chk_diff[7:0] == BYTE_ZERO));
  endproperty
  a_subtract: assert property (p_subtract) else $error("subtract with borrow wrong");

  property p_skip_timing;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    s_take_skip |=> s_dummy_then_run;
  endproperty
  a_skip_timing: assert property (p_skip_timing)
    else $error("skip did not take two cycles");

  property p_no_skip;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    take && !alu_bus.skip |=> o_ready && !o_skip;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("non-skip took extra cycle");

  property p_set;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_set_byte || chk_op == op_set_bit) |-> o_mem_we
      && (o_mem_wdata == ((chk_op == op_set_byte) ? BYTE_ONES
                          : (chk_mem | (BYTE_ONE << chk_bit))));
  endproperty
  a_set: assert property (p_set) else $error("set result wrong");

  property p_bit_skip;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_bit_nonzero_skip) |-> (o_skip == chk_mem[chk_bit]) && !o_mem_we
      && $stable(o_accumulator);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip decision wrong");

  property p_sub_flags;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_subtract_borrow_to_acc || chk_op == op_subtract_borrow_to_mem)
      |-> (o_half_carry_flag == (chk_diff[4] ^ chk_acc[4] ^ ~chk_mem[4]))
      && (o_overflow_flag == (chk_diff[8] ^ chk_diff[7] ^ chk_acc[7] ^ ~chk_mem[7]))
      && (o_accumulator == ((chk_op == op_subtract_borrow_to_acc) ? chk_diff[7:0] : chk_acc));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

  property p_step_acc;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    o_done && (chk_op == op_decrement_skip_zero_to_acc || chk_op == op_increment_skip_zero_to_acc)
      |-> !o_mem_we && $stable(o_carry_flag) && (o_skip == (o_accumulator == BYTE_ZERO))
      && (o_accumulator == ((chk_op == op_decrement_skip_zero_to_acc)
                            ? (chk_mem - BYTE_ONE) : (chk_mem + BYTE_ONE)));
  endproperty
  a_step_acc: assert property (p_step_acc) else $error("step to acc wrong");

endmodule

// ===== verilog/mrssd_pkg.sv
// Operation
// - return restores pc, sets global interrupt enable
// - rotate left memory byte in place
// - rotate left into accumulator, memory kept
// - rotate left through carry into memory
// - rotate left through carry into accumulator
// - rotate right memory byte in place
// - rotate right into accumulator, memory kept
// - rotate right through carry into memory
// - rotate right through carry into accumulator
// - subtract with borrow into accumulator, flags
// - subtract with borrow into memory, flags
// - decrement memory, skip when zero
// - decrement into accumulator, skip when zero
// - set whole memory byte to ones
// - set selected memory bit only
// - increment memory, skip when zero
// - increment into accumulator, skip when zero
// - skip when selected bit is one
package mrssd_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          DATA_W       = 8;
  localparam int          PC_W         = 12;
  localparam int          BIT_SEL_W    = 3;
  localparam int          MSB          = DATA_W - 1;
  localparam logic [7:0]  BYTE_ONES    = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_ONE     = 8'h01;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic        FLAG_RST     = 1'b0;
  localparam logic        GIE_RST      = 1'b0;
  localparam int          HALF_BIT     = 4;
  localparam int          DUMMY_CYCLES = 1;

  // ----------------------------------------------------------------
  // operation selects
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    op_none,
    op_return_from_interrupt,
    op_rotate_left_mem,
    op_rotate_left_to_acc,
    op_rotate_left_carry_mem,
    op_rotate_left_carry_to_acc,
    op_rotate_right_mem,
    op_rotate_right_to_acc,
    op_rotate_right_carry_mem,
    op_rotate_right_carry_to_acc,
    op_subtract_borrow_to_acc,
    op_subtract_borrow_to_mem,
    op_decrement_skip_zero,
    op_decrement_skip_zero_to_acc,
    op_set_byte,
    op_set_bit,
    op_increment_skip_zero,
    op_increment_skip_zero_to_acc,
    op_bit_nonzero_skip
  } mrssd_op_e;

  // result of the add-with-inverted-operand path
  typedef struct packed {
    logic [7:0] sum;
    logic       carry;
    logic       half_carry;
    logic       overflow;
  } mrssd_sum_s;

endpackage

// ===== verilog/mrssd_alu_if.sv
`timescale 1ns/1ps
interface mrssd_alu_if;
  import mrssd_pkg::*;

  // operands
  mrssd_op_e  op;
  logic [2:0] bit_sel;
  logic [7:0] mem;
  logic [7:0] acc;
  logic       carry;
  // results
  logic [7:0] result;
  logic       carry_out;
  logic       overflow;
  logic       half_carry;
  logic       zero;
  logic       wr_mem;
  logic       wr_acc;
  logic       wr_carry;
  logic       wr_arith;
  logic       skip;
  logic       pc_load;

  modport calc (input op, bit_sel, mem, acc, carry,
                output result, carry_out, overflow, half_carry, zero,
                       wr_mem, wr_acc, wr_carry, wr_arith, skip, pc_load);
  modport user (output op, bit_sel, mem, acc, carry,
                input result, carry_out, overflow, half_carry, zero,
                      wr_mem, wr_acc, wr_carry, wr_arith, skip, pc_load);
endinterface

// ===== verilog/mrssd_alu.sv
`timescale 1ns/1ps
module mrssd_alu (
  // operands in, results out
  mrssd_alu_if.calc a
);
  import mrssd_pkg::*;

  // accumulator plus inverted operand plus carry
  function automatic mrssd_sum_s sub_borrow(input logic [7:0] x, input logic [7:0] m,
                                            input logic c);
    logic [8:0] full;
    logic [4:0] low;
    mrssd_sum_s s;
    full         = {1'b0, x} + {1'b0, ~m} + {8'h00, c};
    low          = {1'b0, x[3:0]} + {1'b0, ~m[3:0]} + {4'h0, c};
    s.sum        = full[7:0];
    s.carry      = full[8];
    s.half_carry = low[HALF_BIT];
    s.overflow   = (x[MSB] == ~m[MSB]) && (full[MSB] != x[MSB]);
    return s;
  endfunction

  // zero test shared by skip decisions and flag
  function automatic logic is_zero(input logic [7:0] v);
    return v == BYTE_ZERO;
  endfunction

  mrssd_sum_s diff;
  assign diff = sub_borrow(a.acc, a.mem, a.carry);

  // decode and compute one operation
  always_comb
  begin
    a.result     = a.mem;
    a.carry_out  = a.carry;
    a.overflow   = diff.overflow;
    a.half_carry = diff.half_carry;
    a.wr_mem     = 1'b0;
    a.wr_acc     = 1'b0;
    a.wr_carry   = 1'b0;
    a.wr_arith   = 1'b0;
    a.skip       = 1'b0;
    a.pc_load    = 1'b0;
    case (a.op)
      op_return_from_interrupt:
        a.pc_load = 1'b1;
      op_rotate_left_mem:
      begin
        a.result = {a.mem[6:0], a.mem[MSB]};
        a.wr_mem = 1'b1;
      end
      op_rotate_left_to_acc:
      begin
        a.result = {a.mem[6:0], a.mem[MSB]};
        a.wr_acc = 1'b1;
      end
      op_rotate_left_carry_mem,
      op_rotate_left_carry_to_acc:
      begin
        a.result    = {a.mem[6:0], a.carry};
        a.carry_out = a.mem[MSB];
        a.wr_carry  = 1'b1;
        a.wr_mem    = (a.op == op_rotate_left_carry_mem);
        a.wr_acc    = (a.op == op_rotate_left_carry_to_acc);
      end
      op_rotate_right_mem:
      begin
        a.result = {a.mem[0], a.mem[MSB:1]};
        a.wr_mem = 1'b1;
      end
      op_rotate_right_to_acc:
      begin
        a.result = {a.mem[0], a.mem[MSB:1]};
        a.wr_acc = 1'b1;
      end
      op_rotate_right_carry_mem,
      op_rotate_right_carry_to_acc:
      begin
        a.result    = {a.carry, a.mem[MSB:1]};
        a.carry_out = a.mem[0];
        a.wr_carry  = 1'b1;
        a.wr_mem    = (a.op == op_rotate_right_carry_mem);
        a.wr_acc    = (a.op == op_rotate_right_carry_to_acc);
      end
      op_subtract_borrow_to_acc,
      op_subtract_borrow_to_mem:
      begin
        a.result    = diff.sum;
        a.carry_out = diff.carry;
        a.wr_carry  = 1'b1;
        a.wr_arith  = 1'b1;
        a.wr_mem    = (a.op == op_subtract_borrow_to_mem);
        a.wr_acc    = (a.op == op_subtract_borrow_to_acc);
      end
      op_decrement_skip_zero,
      op_decrement_skip_zero_to_acc:
      begin
        a.result = a.mem - BYTE_ONE;
        a.skip   = is_zero(a.mem - BYTE_ONE);
        a.wr_mem = (a.op == op_decrement_skip_zero);
        a.wr_acc = (a.op == op_decrement_skip_zero_to_acc);
      end
      op_increment_skip_zero,
      op_increment_skip_zero_to_acc:
      begin
        a.result = a.mem + BYTE_ONE;
        a.skip   = is_zero(a.mem + BYTE_ONE);
        a.wr_mem = (a.op == op_increment_skip_zero);
        a.wr_acc = (a.op == op_increment_skip_zero_to_acc);
      end
      op_set_byte:
      begin
        a.result = BYTE_ONES;
        a.wr_mem = 1'b1;
      end
      op_set_bit:
      begin
        a.result = a.mem | (BYTE_ONE << a.bit_sel);
        a.wr_mem = 1'b1;
      end
      op_bit_nonzero_skip:
        a.skip = a.mem[a.bit_sel];
      default:
        a.result = a.mem;
    endcase
  end

  // zero flag value for the subtract forms
  assign a.zero = is_zero(diff.sum);
endmodule

// ===== verif/mcu_rotate_subtract_skip_datapath_tb.sv
`timescale 1ns/1ps
module mcu_rotate_subtract_skip_datapath_tb;
  import mrssd_pkg::*;

  // ----------------------------------------------------------------
  // design ports
  // ----------------------------------------------------------------
  logic        i_ref_clk;
  logic        i_resetn;
  logic        i_op_valid;
  mrssd_op_e   i_op;
  logic [2:0]  i_bit_sel;
  logic [7:0]  i_addr;
  logic        o_ready;
  logic [7:0]  i_mem_rdata;
  logic        o_mem_we;
  logic [7:0]  o_mem_addr;
  logic [7:0]  o_mem_wdata;
  logic [11:0] i_stack_top;
  logic        o_stack_pop;
  logic        o_pc_load;
  logic [11:0] o_pc_value;
  logic        o_skip;
  logic        o_done;
  logic        i_gie_clear;
  logic        o_global_interrupt_enable;
  logic [7:0]  o_accumulator;
  logic        o_carry_flag;
  logic        o_zero_flag;
  logic        o_overflow_flag;
  logic        o_half_carry_flag;

  // ----------------------------------------------------------------
  // model state and bookkeeping
  // ----------------------------------------------------------------
  logic [7:0]  e_acc;
  logic [7:0]  e_wdata;
  logic [7:0]  e_addr;
  logic [11:0] e_pc;
  logic        e_c;
  logic        e_z;
  logic        e_ov;
  logic        e_ac;
  logic        e_gie;
  logic        e_we;
  logic        e_skip;
  logic        e_done;
  logic        e_pop;
  logic        e_wd_care;
  logic [7:0]  edge_vals [3] = '{8'h00, 8'h01, 8'hFF};
  int          errors;
  int          compares;
  int          cycles;

  mrssd_core u_mrssd_core (
    .i_ref_clk, .i_resetn, .i_op_valid, .i_op, .i_bit_sel, .i_addr, .o_ready,
    .i_mem_rdata, .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_stack_top,
    .o_stack_pop, .o_pc_load, .o_pc_value, .o_skip, .o_done, .i_gie_clear,
    .o_global_interrupt_enable, .o_accumulator, .o_carry_flag, .o_zero_flag,
    .o_overflow_flag, .o_half_carry_flag
  );

  // clock, 100 ns period
  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // hang guard
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // model back to reset values
  task automatic rst_model();
    {e_acc, e_wdata, e_addr, e_pc} = '0;
    {e_c, e_z, e_ov, e_ac, e_gie, e_we, e_skip, e_done, e_pop} = '0;
    e_wd_care = 1'b1;
  endtask

  task automatic check_all();
    check(12'(o_done), 12'(e_done));
    check(12'(o_ready), 12'(!e_skip));
    check(12'(o_skip), 12'(e_skip));
    check(12'(o_mem_we), 12'(e_we));
    check(12'(o_mem_addr), 12'(e_addr));
    if (e_wd_care)
      check(12'(o_mem_wdata), 12'(e_wdata));
    check(12'(o_stack_pop), 12'(e_pop));
    check(12'(o_pc_load), 12'(e_pop));
    check(o_pc_value, e_pc);
    check(12'(o_global_interrupt_enable), 12'(e_gie));
    check(12'(o_accumulator), 12'(e_acc));
    check(12'(o_carry_flag), 12'(e_c));
    check(12'(o_zero_flag), 12'(e_z));
    check(12'(o_overflow_flag), 12'(e_ov));
    check(12'(o_half_carry_flag), 12'(e_ac));
  endtask

  // expected outputs one edge after the current request
  task automatic model_step();
    int         r;
    int         s;
    int         h;
    logic [7:0] m;
    logic       tk;
    m = i_mem_rdata;
    tk = i_op_valid && !e_skip;
    s = e_acc + (255 - m) + e_c;
    h = (e_acc & 15) + (15 - (m & 15)) + e_c;
    e_done = tk;
    e_we = 1'b0;
    e_pop = 1'b0;
    if (i_gie_clear)
      e_gie = 1'b0;
    if (!tk)
    begin
      e_skip = 1'b0;
      return;
    end
    case (i_op)
      op_rotate_left_mem, op_rotate_left_to_acc: r = {m[6:0], m[7]};
      op_rotate_left_carry_mem, op_rotate_left_carry_to_acc: r = {m[6:0], e_c};
      op_rotate_right_mem, op_rotate_right_to_acc: r = {m[0], m[7:1]};
      op_rotate_right_carry_mem, op_rotate_right_carry_to_acc: r = {e_c, m[7:1]};
      op_subtract_borrow_to_acc, op_subtract_borrow_to_mem: r = s & 255;
      op_decrement_skip_zero, op_decrement_skip_zero_to_acc: r = (m + 255) & 255;
      op_increment_skip_zero, op_increment_skip_zero_to_acc: r = (m + 1) & 255;
      op_set_byte: r = 255;
      op_set_bit: r = m | (1 << i_bit_sel);
      default: r = m;
    endcase
    e_addr = i_addr;
    e_wdata = r[7:0];
    e_wd_care = !(i_op inside {op_return_from_interrupt, op_bit_nonzero_skip});
    e_we = i_op inside {op_rotate_left_mem, op_rotate_left_carry_mem, op_rotate_right_mem,
      op_rotate_right_carry_mem, op_subtract_borrow_to_mem, op_decrement_skip_zero,
      op_set_byte, op_set_bit, op_increment_skip_zero};
    if (i_op inside {op_rotate_left_carry_mem, op_rotate_left_carry_to_acc})
      e_c = m[7];
    if (i_op inside {op_rotate_right_carry_mem, op_rotate_right_carry_to_acc})
      e_c = m[0];
    if (i_op inside {op_subtract_borrow_to_acc, op_subtract_borrow_to_mem})
    begin
      e_ov = (e_acc[7] == !m[7]) && (r[7] != e_acc[7]);
      e_c = (s > 255);
      e_z = (r == 0);
      e_ac = (h > 15);
    end
    if (i_op inside {op_rotate_left_to_acc, op_rotate_left_carry_to_acc,
      op_rotate_right_to_acc, op_rotate_right_carry_to_acc, op_subtract_borrow_to_acc,
      op_decrement_skip_zero_to_acc, op_increment_skip_zero_to_acc})
      e_acc = r[7:0];
    e_skip = ((i_op inside {op_decrement_skip_zero, op_decrement_skip_zero_to_acc,
      op_increment_skip_zero, op_increment_skip_zero_to_acc}) && r == 0)
      || (i_op == op_bit_nonzero_skip && m[i_bit_sel]);
    if (i_op == op_return_from_interrupt)
    begin
      e_pc = i_stack_top;
      e_pop = 1'b1;
      e_gie = 1'b1;
    end
  endtask

  // main sequence
  initial
  begin
    void'($urandom(76));
    {i_op_valid, i_bit_sel, i_addr, i_mem_rdata, i_stack_top, i_gie_clear} = '0;
    i_op = op_none;
    i_resetn = 1'b0;
    rst_model();
    repeat (4) @(posedge i_ref_clk);
    #1;
    check_all();
    i_resetn = 1'b1;
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge i_ref_clk);
      #1;
      check_all();
      if (n == 1500)
      begin
        i_resetn = 1'b0;
        #5;
        rst_model();
        check_all();
        @(posedge i_ref_clk);
        #1;
        i_resetn = 1'b1;
      end
      i_op_valid = ($urandom_range(7) != 0);
      i_op = mrssd_op_e'($urandom_range(18));
      i_bit_sel = 3'($urandom);
      i_addr = 8'($urandom);
      i_mem_rdata = ($urandom_range(3) == 0) ? edge_vals[$urandom_range(2)] : 8'($urandom);
      i_stack_top = 12'($urandom);
      i_gie_clear = ($urandom_range(7) == 0);
      model_step();
    end
    final_report();
  end
endmodule
